// >>> core/option_latch_bank.sv
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module option_latch_bank
  import option_latch_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and resets
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic por_in,

  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,

  // stop control
  input wire logic stop_req_in,
  input wire logic wake_in,
  input wire logic monitor_wake_in,
  input wire logic xtal_tick_in,
  output logic illegal_opcode_out,
  output logic stop_mode_out,

  // clock steering
  input wire logic tb_tick_in,
  input wire logic bus_tick_in,
  input wire logic osc_tick_in,
  output logic tb_tick_out,
  output logic baud_tick_out,
  output logic osc_run_out,
  output logic loop_run_out,
  output logic clock_outputs_enable_out,

  // watchdog and low-voltage monitor
  input wire logic monitor_reset_req_in,
  output logic watchdog_enable_out,
  output logic [17:0] watchdog_timeout_out,
  output logic monitor_power_out,
  output logic monitor_trip_5v_out,
  output logic monitor_reset_out,
  output logic [10:0] options_out
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ONE_ADDR =
    ADDR_W'({OPT_ONE_INDEX, 2'b00});
  localparam logic [ADDR_W-1:0] TWO_ADDR =
    ADDR_W'({OPT_TWO_INDEX, 2'b00});
  localparam logic [6:0] TB_LAST = 7'(TIMEBASE_DIVIDE - 1);

  logic hit_one;
  logic hit_two;
  logic setup;
  logic access;
  logic wr_take;

  assign hit_one = (paddr_in == ONE_ADDR);
  assign hit_two = (paddr_in == TWO_ADDR);
  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in;
  assign wr_take = access && pwrite_in;

  // zero wait states; read data captured in the setup cycle
  assign pready_out = 1'b1;
  assign pslverr_out = access && !(hit_one || hit_two);

  // ----------------------------------------------------------------
  // option latches
  // ----------------------------------------------------------------
  logic [7:0] opt_one;
  logic [7:0] opt_two;
  logic supply_mode;
  logic one_written;
  logic two_written;
  logic supply_written;
  logic [7:0] next_opt_one;
  logic [7:0] next_opt_two;
  logic next_supply_mode;
  logic next_one_written;
  logic next_two_written;
  logic next_supply_written;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  logic [7:0] one_view;

  // supply bit lives apart so ordinary resets leave it alone
  always_comb begin
    one_view = opt_one;
    one_view[SUPPLY_MODE_BIT] = supply_mode;
  end

  always_comb begin
    next_opt_one = opt_one;
    next_opt_two = opt_two;
    next_supply_mode = supply_mode;
    next_one_written = one_written;
    next_two_written = two_written;
    next_supply_written = supply_written;
    next_prdata = prdata;
    if (wr_take && hit_one && !one_written) begin
      next_opt_one = pwdata_in[7:0];
      next_opt_one[SUPPLY_MODE_BIT] = 1'b0;
      next_one_written = 1'b1;
    end
    if (wr_take && hit_one && !supply_written) begin
      next_supply_mode = pwdata_in[SUPPLY_MODE_BIT];
      next_supply_written = 1'b1;
    end
    if (wr_take && hit_two && !two_written) begin
      next_opt_two = pwdata_in[7:0] & OPT_TWO_MASK;
      next_two_written = 1'b1;
    end
    if (setup) begin
      if (hit_one) begin
        next_prdata = {24'h00_0000, one_view};
      end else if (hit_two) begin
        next_prdata = {24'h00_0000, opt_two};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (por_in) begin
      opt_one <= OPT_RESET;
      opt_two <= OPT_RESET;
      supply_mode <= 1'b0;
      one_written <= 1'b0;
      two_written <= 1'b0;
      supply_written <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (sys_rst_in) begin
      opt_one <= OPT_RESET;
      opt_two <= OPT_RESET;
      one_written <= 1'b0;
      two_written <= 1'b0;
      prdata <= 32'h0000_0000;
      supply_mode <= next_supply_mode;
      supply_written <= next_supply_written;
    end else begin
      opt_one <= next_opt_one;
      opt_two <= next_opt_two;
      supply_mode <= next_supply_mode;
      one_written <= next_one_written;
      two_written <= next_two_written;
      supply_written <= next_supply_written;
      prdata <= next_prdata;
    end
  end

  assign prdata_out = prdata;

  option_set_s opt;

  always_comb begin
    opt.watchdog_rate = opt_one[WATCHDOG_RATE_BIT];
    opt.monitor_in_stop = opt_one[MONITOR_IN_STOP_BIT];
    opt.monitor_reset_disable = opt_one[MONITOR_RESET_DISABLE_BIT];
    opt.monitor_power_disable = opt_one[MONITOR_POWER_DISABLE_BIT];
    opt.monitor_supply_mode = supply_mode;
    opt.short_recovery = opt_one[SHORT_RECOVERY_BIT];
    opt.stop_enable = opt_one[STOP_ENABLE_BIT];
    opt.watchdog_disable = opt_one[WATCHDOG_DISABLE_BIT];
    opt.timebase_prescale_select = opt_two[TIMEBASE_PRESCALE_BIT];
    opt.oscillator_in_stop = opt_two[OSCILLATOR_IN_STOP_BIT];
    opt.serial_baud_source = opt_two[SERIAL_BAUD_SOURCE_BIT];
  end

  assign options_out = opt;

  // ----------------------------------------------------------------
  // stop sequencing
  // ----------------------------------------------------------------
  stop_state_e state;
  stop_state_e next_state;
  logic illegal;
  logic next_illegal;
  logic rec_start;
  logic rec_long;
  logic rec_busy;
  logic rec_done;

  always_comb begin
    next_state = state;
    next_illegal = 1'b0;
    rec_start = 1'b0;
    rec_long = 1'b1;
    case (state)
      RUN_ST: begin
        if (stop_req_in) begin
          if (opt.stop_enable) begin
            next_state = STOP_ST;
          end else begin
            next_illegal = 1'b1;
          end
        end
      end
      STOP_ST: begin
        if (monitor_wake_in) begin
          rec_start = 1'b1;
          rec_long = 1'b1;
          next_state = RECOVER_ST;
        end else if (wake_in) begin
          rec_start = 1'b1;
          rec_long = !opt.short_recovery;
          next_state = RECOVER_ST;
        end
      end
      RECOVER_ST: begin
        if (rec_done) begin
          next_state = RUN_ST;
        end
      end
      default: begin
        next_state = RUN_ST;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || por_in) begin
      state <= RUN_ST;
      illegal <= 1'b0;
    end else begin
      state <= next_state;
      illegal <= next_illegal;
    end
  end

  stop_recovery_timer u_recovery (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in || por_in),
    .start_in(rec_start),
    .long_in(rec_long),
    .xtal_tick_in(xtal_tick_in),
    .busy_out(rec_busy),
    .done_out(rec_done)
  );

  logic stopped;

  // recovery counts as stopped until the oscillator has settled
  assign stopped = (state != RUN_ST) || rec_busy;
  assign stop_mode_out = stopped;
  assign illegal_opcode_out = illegal;

  assign osc_run_out = !stopped || opt.oscillator_in_stop;
  assign loop_run_out = !stopped;
  assign clock_outputs_enable_out = !stopped || opt.oscillator_in_stop;

  // ----------------------------------------------------------------
  // clock steering
  // ----------------------------------------------------------------
  logic [6:0] tb_count;
  logic [6:0] next_tb_count;
  logic tb_tick;
  logic next_tb_tick;
  logic baud_tick;
  logic next_baud_tick;

  always_comb begin
    next_tb_count = tb_count;
    next_tb_tick = 1'b0;
    if (opt.timebase_prescale_select) begin
      if (tb_tick_in) begin
        next_tb_count = tb_count + 7'h01;
        next_tb_tick = (tb_count == TB_LAST);
      end
    end else begin
      next_tb_count = 7'h00;
      next_tb_tick = tb_tick_in;
    end
    next_baud_tick = opt.serial_baud_source ? bus_tick_in : osc_tick_in;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || por_in) begin
      tb_count <= 7'h00;
      tb_tick <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      tb_count <= next_tb_count;
      tb_tick <= next_tb_tick;
      baud_tick <= next_baud_tick;
    end
  end

  assign tb_tick_out = tb_tick;
  assign baud_tick_out = baud_tick;

  // ----------------------------------------------------------------
  // watchdog and monitor controls
  // ----------------------------------------------------------------
  // watchdog disable
  assign watchdog_enable_out = !opt.watchdog_disable;
  assign watchdog_timeout_out =
    opt.watchdog_rate ? WATCHDOG_SHORT_CYCLES : WATCHDOG_LONG_CYCLES;
  assign monitor_power_out = !opt.monitor_power_disable &&
    (!stopped || opt.monitor_in_stop);
  assign monitor_trip_5v_out = opt.monitor_supply_mode;
  assign monitor_reset_out = monitor_reset_req_in &&
    !opt.monitor_reset_disable && monitor_power_out;

endmodule

// >>> core/option_latch_pkg.sv
// Notes on behaviour
// - each option register takes exactly one software write per reset
// - any reset clears all option bits except the supply-mode bit
// - registers sit at indices 1E and 1F, readable at any time
// - supply-mode bit cleared only by power-on, writable once per power-on
// - timebase select set inserts divide-by-128, clear bypasses it
// - oscillator-in-stop set keeps oscillator running during stop
// - baud source set uses bus clock, clear uses external oscillator
// - watchdog rate: 1 gives 8176 cycles, 0 gives 262128; reset clears
// - monitor-in-stop keeps monitor running in stop when power enabled
// - monitor reset-disable set suppresses monitor resets
// - monitor power-disable set powers the monitor down
// - supply-mode bit selects 5-V trip when 1, 3-V when 0
// - short recovery: 32 crystal cycles, else 4096 crystal cycles
// - stop exit by monitor reset always uses long recovery
// - stop-enable clear makes stop instruction an illegal opcode
// - watchdog disable bit set disables the watchdog
// - in stop, loop always off; oscillator off unless oscillator-in-stop set
package option_latch_pkg;

  // ----------------------------------------------------------------
  // register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] OPT_TWO_INDEX = 8'h1E;
  localparam logic [7:0] OPT_ONE_INDEX = 8'h1F;
  localparam logic [7:0] OPT_RESET = 8'h00;

  // ----------------------------------------------------------------
  // option_latch_one fields
  // ----------------------------------------------------------------
  localparam int WATCHDOG_DISABLE_BIT = 0;
  localparam int STOP_ENABLE_BIT = 1;
  localparam int SHORT_RECOVERY_BIT = 2;
  localparam int SUPPLY_MODE_BIT = 3;
  localparam int MONITOR_POWER_DISABLE_BIT = 4;
  localparam int MONITOR_RESET_DISABLE_BIT = 5;
  localparam int MONITOR_IN_STOP_BIT = 6;
  localparam int WATCHDOG_RATE_BIT = 7;

  // ----------------------------------------------------------------
  // option_latch_two fields, upper bits read zero
  // ----------------------------------------------------------------
  localparam int SERIAL_BAUD_SOURCE_BIT = 0;
  localparam int OSCILLATOR_IN_STOP_BIT = 1;
  localparam int TIMEBASE_PRESCALE_BIT = 2;
  localparam logic [7:0] OPT_TWO_MASK = 8'h07;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam int unsigned TIMEBASE_DIVIDE = 128;
  localparam int unsigned RECOVERY_SHORT_CYCLES = 32;
  localparam int unsigned RECOVERY_LONG_CYCLES = 4096;
  localparam logic [17:0] WATCHDOG_SHORT_CYCLES = 18'h0_1FF0;
  localparam logic [17:0] WATCHDOG_LONG_CYCLES = 18'h3_FFF0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic watchdog_rate;
    logic monitor_in_stop;
    logic monitor_reset_disable;
    logic monitor_power_disable;
    logic monitor_supply_mode;
    logic short_recovery;
    logic stop_enable;
    logic watchdog_disable;
    logic timebase_prescale_select;
    logic oscillator_in_stop;
    logic serial_baud_source;
  } option_set_s;

  typedef enum logic [1:0] {
    RUN_ST,
    STOP_ST,
    RECOVER_ST
  } stop_state_e;

endpackage

// >>> core/stop_recovery_timer.sv
`timescale 1ns/1ns
module stop_recovery_timer
  import option_latch_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // control
  input wire logic start_in,
  input wire logic long_in,
  input wire logic xtal_tick_in,
  // status
  output logic busy_out,
  output logic done_out
);

  localparam logic [12:0] LONG_LOAD = 13'(RECOVERY_LONG_CYCLES);
  localparam logic [12:0] SHORT_LOAD = 13'(RECOVERY_SHORT_CYCLES);

  logic [12:0] count;
  logic [12:0] next_count;
  logic done;
  logic next_done;

  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (start_in) begin
      next_count = long_in ? LONG_LOAD : SHORT_LOAD;
    end else if (count != 13'h0000 && xtal_tick_in) begin
      next_count = count - 13'h0001;
      next_done = (count == 13'h0001);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      count <= 13'h0000;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign busy_out = (count != 13'h0000);
  assign done_out = done;

endmodule

// >>> tb/option_latch_checker.sv
`timescale 1ns/1ns
module option_latch_checker
  import option_latch_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // clock and resets
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic por_in,
  // apb
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // stop and clocks
  input wire logic stop_req_in,
  input wire logic illegal_opcode_out,
  input wire logic stop_mode_out,
  input wire logic bus_tick_in,
  input wire logic osc_tick_in,
  input wire logic baud_tick_out,
  input wire logic osc_run_out,
  input wire logic loop_run_out,
  // watchdog and monitor
  input wire logic [17:0] watchdog_timeout_out,
  input wire logic monitor_power_out,
  input wire logic monitor_trip_5v_out,
  input wire logic monitor_reset_req_in,
  input wire logic monitor_reset_out,
  input wire logic [10:0] options_out
);
  option_set_s o;
  logic quiet;
  logic mapped;
  assign o = option_set_s'(options_out);
  assign mapped = paddr_in == 'h78 || paddr_in == 'h7C;
  // registered so a tick during reset is never compared
  always_ff @(posedge mclk_in) begin
    quiet <= !(sys_rst_in || por_in);
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in || por_in);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_SLVERR_MAP: assert property (psel_in && penable_in |->
    pready_out && pslverr_out == !mapped) else $error("bad apb answer");
  AST_STOP_ANSWER: assert property (stop_req_in && !stop_mode_out
    |=> illegal_opcode_out != stop_mode_out &&
    stop_mode_out == $past(o.stop_enable))
    else $error("bad stop answer");
  AST_STOP_CLOCKS: assert property ($rose(stop_mode_out) |->
    osc_run_out == o.oscillator_in_stop && !loop_run_out)
    else $error("bad clocks in stop");
  AST_BAUD_SRC: assert property (quiet |-> baud_tick_out ==
    ($past(o.serial_baud_source) ? $past(bus_tick_in) : $past(osc_tick_in)))
    else $error("bad baud source");
  AST_WD_TIMEOUT: assert property (watchdog_timeout_out ==
    (o.watchdog_rate ? WATCHDOG_SHORT_CYCLES : WATCHDOG_LONG_CYCLES))
    else $error("bad watchdog timeout");
  AST_MON_POWER: assert property ($changed(o.monitor_power_disable)
    |-> monitor_power_out != $past(monitor_power_out))
    else $error("bad power");
  AST_MON_TRIP: assert property (monitor_trip_5v_out ==
    o.monitor_supply_mode) else $error("bad trip mode");
  // an unpowered monitor cannot raise a reset, so stop gating counts too
  AST_MON_RESET: assert property (monitor_reset_out ==
    (monitor_reset_req_in && !o.monitor_reset_disable &&
    !o.monitor_power_disable && (!stop_mode_out || o.monitor_in_stop)))
    else $error("bad monitor reset");
endmodule

bind option_latch_bank option_latch_checker #(.ADDR_W(ADDR_W)) chk (.*);

// >>> tb/option_latch_bank_test.sv
`timescale 1ns/1ns
module option_latch_bank_test;
  import option_latch_pkg::*;
  logic mclk_in = 0, sys_rst_in = 1, por_in = 1;
  logic psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd, r;
  logic pready_out, pslverr_out, err, illegal_opcode_out, stop_mode_out;
  logic stop_req_in = 0, wake_in = 0, monitor_wake_in = 0, xtal_tick_in = 0;
  logic tb_tick_in = 0, bus_tick_in = 0, osc_tick_in = 0;
  logic monitor_reset_req_in = 0;
  logic tb_tick_out, baud_tick_out, osc_run_out, loop_run_out;
  logic clock_outputs_enable_out, watchdog_enable_out, monitor_power_out;
  logic monitor_trip_5v_out, monitor_reset_out;
  logic [17:0] watchdog_timeout_out;
  logic [10:0] options_out;
  logic [7:0] v1, v2, e1, e2;
  logic sup_val = 0, sup_done = 0;
  int failures = 0, checks = 0, cyc = 0, seed = 32'h633bee13;
  int ti, bi, to, bo, n, lim;

  option_latch_bank dut (.*);

  initial forever #5 mclk_in = ~mclk_in;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one edge first, so back to back calls never drive psel twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h00_0000, d};
    @(posedge mclk_in);
    penable_in <= 1;
    @(posedge mclk_in);
    while (pready_out !== 1'b1) @(posedge mclk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask

  task automatic do_reset(input logic p);
    @(posedge mclk_in);
    sys_rst_in <= 1;
    por_in <= p;
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 0;
    por_in <= 0;
    if (p) begin
      sup_val = 0;
      sup_done = 0;
    end
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      report_and_stop;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 6; i++) begin
      do_reset(i % 3 == 0);
      apb(0, 12'h07C, 8'h00);
      check("one_rst", rd, {28'h0, sup_val, 3'b000});
      apb(0, 12'h078, 8'h00);
      check("two_rst", rd, 32'h0);
      apb(1, 12'h080, 8'hA5);
      check("umap_err", err, 1'b1);
      apb(0, 12'h080, 8'h00);
      check("umap_rd", rd, 32'h0);
      v1 = 8'($random(seed));
      v2 = 8'($random(seed));
      v1[1] = (i != 2);
      v1[2] = i[0] | (i == 4);
      v1[3] = i[0];
      // no short recovery with halted oscillator
      if (v1[2]) v2[1] = 1;
      e1 = v1;
      e2 = v2 & OPT_TWO_MASK;
      if (sup_done) begin
        e1[3] = sup_val;
      end else begin
        sup_val = v1[3];
        sup_done = 1;
      end
      apb(1, 12'h07C, v1);
      apb(1, 12'h078, v2);
      apb(1, 12'h07C, ~v1);
      apb(1, 12'h078, ~v2);
      apb(0, 12'h07C, 8'h00);
      check("one_rd", rd, e1);
      apb(0, 12'h078, 8'h00);
      check("two_rd", rd, e2);
      check("opts", options_out, {e1, e2[2:0]});
      check("wd_en", watchdog_enable_out, !e1[0]);
      {ti, bi, to, bo} = 0;
      for (int k = 0; k < 603; k++) begin
        @(posedge mclk_in);
        to += tb_tick_out;
        bo += baud_tick_out;
        r = (k < 600) ? $random(seed) : 0;
        tb_tick_in <= r[0];
        bus_tick_in <= r[1];
        osc_tick_in <= r[2];
        monitor_reset_req_in <= r[3];
        ti += r[0];
        bi += e2[0] ? r[1] : r[2];
      end
      check("tb_ticks", to, e2[2] ? ti / 128 : ti);
      check("baud_ticks", bo, bi);
      @(posedge mclk_in);
      stop_req_in <= 1;
      @(posedge mclk_in);
      stop_req_in <= 0;
      @(posedge mclk_in);
      check("stop", stop_mode_out, e1[1]);
      check("illegal", illegal_opcode_out, !e1[1]);
      if (e1[1]) begin
        check("osc", osc_run_out, e2[1]);
        check("clk_en", clock_outputs_enable_out, e2[1]);
        check("loop", loop_run_out, 1'b0);
        check("mon_pwr", monitor_power_out, !e1[4] && e1[6]);
        wake_in <= (i != 4);
        monitor_wake_in <= (i == 4);
        xtal_tick_in <= 1;
        @(posedge mclk_in);
        wake_in <= 0;
        monitor_wake_in <= 0;
        n = 0;
        while (stop_mode_out !== 1'b0 && n < 5000) begin
          @(posedge mclk_in);
          n++;
        end
        xtal_tick_in <= 0;
        check("osc_back", osc_run_out && loop_run_out, 1'b1);
        lim = (e1[2] && i != 4) ? RECOVERY_SHORT_CYCLES : RECOVERY_LONG_CYCLES;
        check("recovery", n >= lim && n <= lim + 4, 1'b1);
      end
    end
    report_and_stop;
  end
endmodule
